// >>> scms_regs.svh
// Offsets, field positions, reset values and command codes of the programming block
`ifndef SCMS_REGS_SVH
`define SCMS_REGS_SVH
`define SCMS_CMD_RW_BIT 7
`define SCMS_CMD_CHEN 8'hA3
`define SCMS_CHEN_RESET 8'h00
`define SCMS_OFF_LOCAL_ONE 5'h00
`define SCMS_OFF_LOCAL_TWO 5'h01
`define SCMS_OFF_MASK 5'h11
`define SCMS_OFF_STATUS 5'h14
`define SCMS_OFF_CHEN 5'h03
`define SCMS_CMD_COE_WR 8'hE0
`define SCMS_CMD_COE_RD 8'h60
`define SCMS_COE_BYTES 5'h10
`define SCMS_COE_WORD_BITS 14
`define SCMS_BIT_FEEDI 7
`define SCMS_BIT_FEEDV 6
`define SCMS_BIT_FEEDR 5
`define SCMS_BIT_LMDONE 4
`define SCMS_BIT_TONE 3
`define SCMS_BIT_OVER_TEMPERATURE 2
`define SCMS_BIT_RAMP 1
`define SCMS_BIT_GKPOL 0
`define SCMS_MASK_RESET 8'h07
`define SCMS_LOCAL_RESET 8'h00
`define SCMS_GKPOL_RESET 1'b1
`define SCMS_ID_BYTE 8'h5A
`endif

// >>> scms_pkg.sv
// Types shared by the programming block
package scms_pkg;
	typedef enum logic [3:0] {
		SCMS_IDLE = 4'b0001,
		SCMS_CHEN = 4'b0010,
		SCMS_WRITE = 4'b0100,
		SCMS_READ = 4'b1000
	} scms_state_t;
endpackage : scms_pkg

// >>> scms_evt_if.sv
// Event detector bundle between the top and the edge detector
`timescale 1ns/1ps
interface scms_evt_if;
	logic [4:0] level;
	logic [4:0] event_pulse;
	modport det (input level, output event_pulse);
	modport top (output level, input event_pulse);
endinterface : scms_evt_if

// >>> scms_edge_det.sv
// Synchroniser and change detector for the status event sources
`timescale 1ns/1ps
module scms_edge_det (
	input wire logic sys_clk,
	input wire logic resetn,
	scms_evt_if.det evt
);
	typedef struct packed {
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic [4:0] prev;
		logic [4:0] pulse;
	} scms_det_t;
	scms_det_t state_reg;
	scms_det_t state_next;

	// Bits 4..1 fire on rise, bit 0 (polarity) fires on any change
	always_comb begin
		state_next = state_reg;
		state_next.sync1 = evt.level;
		state_next.sync2 = state_reg.sync1;
		state_next.prev = state_reg.sync2;
		state_next.pulse[4:1] = state_reg.sync2[4:1] & ~state_reg.prev[4:1];
		state_next.pulse[0] = state_reg.sync2[0] ^ state_reg.prev[0];
	end

	// Reset values match the documented status defaults
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_reg <= '{sync1: 5'h01, sync2: 5'h01, prev: 5'h01, pulse: 5'h00};
		end else begin
			state_reg <= state_next;
		end
	end
	assign evt.event_pulse = state_reg.pulse;
endmodule : scms_edge_det

// >>> scms_top.sv
// Host programming command interpreter and interrupt status of one channel
`timescale 1ns/1ps
`include "scms_regs.svh"
module scms_top (
	sys_clk,
	resetn,
	hostByteIn,
	hostByteValid,
	hostReadReq,
	channelSelf,
	feedCurrent,
	feedVoltage,
	feedResistive,
	levelDone,
	toneFound,
	overTemp,
	rampDone,
	rampStart,
	gkPositive,
	hostByteOut,
	hostByteOutValid,
	intReqN,
	channelEnable
);
	input wire logic sys_clk;
	input wire logic resetn;
	input wire logic [7:0] hostByteIn;
	input wire logic hostByteValid;
	input wire logic hostReadReq;
	input wire logic [7:0] channelSelf;
	input wire logic feedCurrent;
	input wire logic feedVoltage;
	input wire logic feedResistive;
	input wire logic levelDone;
	input wire logic toneFound;
	input wire logic overTemp;
	input wire logic rampDone;
	input wire logic rampStart;
	input wire logic gkPositive;
	output logic [7:0] hostByteOut;
	output logic hostByteOutValid;
	output logic intReqN;
	output logic [7:0] channelEnable;

	typedef struct packed {
		scms_pkg::scms_state_t fsm;
		logic [7:0] chen;
		logic [7:0] localOne;
		logic [7:0] localTwo;
		logic [7:0] maskBits;
		logic [4:0] pending;
		logic [4:0] addr;
		logic [4:0] count;
		logic coe;
		logic global;
		logic [7:0] coeHigh;
		logic [2:0] rampSync;
		logic rampFlag;
		logic [1:0] startSync;
		logic [4:0] lvlSync1;
		logic [4:0] lvlSync2;
		logic [2:0] feedSync1;
		logic [2:0] feedSync2;
		logic [7:0] outByte;
		logic outValid;
		logic irqN;
	} scms_top_t;

	scms_top_t state_reg;
	scms_top_t state_next;
	logic [13:0] coeMem [0:7];
	logic coeWrite;
	logic [2:0] coeIndex;
	logic [13:0] coeWord;
	logic [7:0] statusByte;
	logic [4:0] levels;
	logic [4:0] maskGate;
	logic selected;
	logic hostByteValidS1;
	logic hostByteValidS2;
	logic hostReadS1;
	logic hostReadS2;
	logic hostRead;
	logic [7:0] hostByteS1;
	logic [7:0] hostByteS2;

	scms_evt_if evt ();

	// Ramp flag is held low after a new ramp until the done level rises again
	assign levels = {levelDone, toneFound, overTemp, state_reg.rampFlag, gkPositive};
	assign evt.level = levels;

	scms_edge_det u_edge (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.evt(evt)
	);

	// Host strobes arrive from outside; double-flop before use
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			hostByteValidS1 <= 1'b0;
			hostByteValidS2 <= 1'b0;
			hostReadS1 <= 1'b0;
			hostReadS2 <= 1'b0;
			hostRead <= 1'b0;
			hostByteS1 <= 8'h00;
			hostByteS2 <= 8'h00;
		end else begin
			hostByteValidS1 <= hostByteValid;
			hostByteValidS2 <= hostByteValidS1;
			hostReadS1 <= hostReadReq;
			hostReadS2 <= hostReadS1;
			hostRead <= hostReadS2;
			hostByteS1 <= hostByteIn;
			hostByteS2 <= hostByteS1;
		end
	end

	logic byteStrobe;
	logic byteSeen;
	logic readStrobe;
	// One pulse per host byte and per host read request
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			byteSeen <= 1'b0;
		end else begin
			byteSeen <= hostByteValidS2;
		end
	end
	assign byteStrobe = hostByteValidS2 & ~byteSeen;
	assign readStrobe = hostReadS2 & ~hostRead;

	// Channel is addressed when its bit appears in the enable register
	assign selected = |(state_reg.chen & channelSelf);

	// Status byte, bit order b7..b0
	always_comb begin
		statusByte = 8'h00;
		statusByte[`SCMS_BIT_FEEDI] = state_reg.feedSync2[2];
		statusByte[`SCMS_BIT_FEEDV] = state_reg.feedSync2[1];
		statusByte[`SCMS_BIT_FEEDR] = state_reg.feedSync2[0];
		// Event levels are read only after their own two-flop crossing
		statusByte[`SCMS_BIT_LMDONE] = state_reg.lvlSync2[4];
		statusByte[`SCMS_BIT_TONE] = state_reg.lvlSync2[3];
		statusByte[`SCMS_BIT_OVER_TEMPERATURE] = state_reg.lvlSync2[2];
		statusByte[`SCMS_BIT_RAMP] = state_reg.lvlSync2[1];
		statusByte[`SCMS_BIT_GKPOL] = state_reg.lvlSync2[0];
	end

	// Level and tone have no mask; others gated by mask register bits
	assign maskGate = {1'b1, 1'b1, ~state_reg.maskBits[`SCMS_BIT_OVER_TEMPERATURE],
		~state_reg.maskBits[`SCMS_BIT_RAMP], ~state_reg.maskBits[`SCMS_BIT_GKPOL]};

	// Coefficient word assembled from high byte (upper bits dropped) and low byte
	// Low byte lands at odd counts: count 15 is word 8, count 1 is word 1
	assign coeIndex = state_reg.count[3:1];
	assign coeWord = {state_reg.coeHigh[5:0], hostByteS2};
	assign coeWrite = (state_reg.fsm == scms_pkg::SCMS_WRITE) && state_reg.coe && byteStrobe
		&& state_reg.count[0] == 1'b1;

	// Coefficient RAM, one block of eight words
	always_ff @(posedge sys_clk) begin
		if (coeWrite) begin
			coeMem[coeIndex] <= coeWord;
		end
	end

	// Command interpreter and status bookkeeping
	always_comb begin
		state_next = state_reg;
		state_next.outValid = 1'b0;
		state_next.feedSync1 = {feedCurrent, feedVoltage, feedResistive};
		state_next.feedSync2 = state_reg.feedSync1;
		state_next.lvlSync1 = levels;
		state_next.lvlSync2 = state_reg.lvlSync1;
		// Done level and start pulse cross in two flops; third done flop is edge memory
		state_next.rampSync = {state_reg.rampSync[1:0], rampDone};
		state_next.startSync = {state_reg.startSync[0], rampStart};
		// A done edge in the same cycle as a start wins; a standing done level is not re-reported
		if (state_reg.rampSync[1] && !state_reg.rampSync[2]) begin
			state_next.rampFlag = 1'b1;
		end else if (state_reg.startSync[1]) begin
			state_next.rampFlag = 1'b0;
		end
		// Event set wins over a read clear; the clear rides on the status byte request itself
		if (readStrobe && state_reg.fsm == scms_pkg::SCMS_READ && !state_reg.coe
			&& !state_reg.global && state_reg.addr == `SCMS_OFF_STATUS) begin
			state_next.pending = 5'h00;
		end
		state_next.pending = state_next.pending | (evt.event_pulse & maskGate);
		state_next.irqN = ~|state_next.pending;
		case (state_reg.fsm)
			scms_pkg::SCMS_IDLE: begin
				if (byteStrobe) begin
					state_next.addr = hostByteS2[4:0];
					state_next.coe = hostByteS2[6:5] == 2'b11;
					state_next.global = hostByteS2[6:5] == 2'b01;
					if (hostByteS2 == `SCMS_CMD_CHEN) begin
						state_next.fsm = scms_pkg::SCMS_CHEN;
					end else if (!selected && hostByteS2[6:5] != 2'b01) begin
						state_next.fsm = scms_pkg::SCMS_IDLE;
					end else if (hostByteS2[`SCMS_CMD_RW_BIT]) begin
						state_next.fsm = scms_pkg::SCMS_WRITE;
						state_next.count = (hostByteS2[6:5] == 2'b11) ? `SCMS_COE_BYTES
							: hostByteS2[4:0] + 5'd1;
					end else begin
						state_next.fsm = scms_pkg::SCMS_READ;
						state_next.count = (hostByteS2[6:5] == 2'b11) ? `SCMS_COE_BYTES
							: hostByteS2[4:0] + 5'd1;
						state_next.outByte = `SCMS_ID_BYTE;
						state_next.outValid = 1'b1;
					end
				end
			end
			scms_pkg::SCMS_CHEN: begin
				if (byteStrobe) begin
					state_next.chen = hostByteS2;
					state_next.fsm = scms_pkg::SCMS_IDLE;
				end
			end
			scms_pkg::SCMS_WRITE: begin
				if (byteStrobe) begin
					if (state_reg.coe) begin
						if (state_reg.count[0] == 1'b1) begin
							state_next.coeHigh = 8'h00;
						end
						if (state_reg.count[0] == 1'b0 && state_reg.count != 5'h00) begin
							state_next.coeHigh = hostByteS2;
						end
					end else if (state_reg.global) begin
						// No writable global register here; the enable byte has its own command
						state_next.addr = state_reg.addr - 5'd1;
					end else begin
						// Descending address, register two before register one
						case (state_reg.addr)
							`SCMS_OFF_LOCAL_TWO: state_next.localTwo = hostByteS2;
							`SCMS_OFF_LOCAL_ONE: state_next.localOne = hostByteS2;
							`SCMS_OFF_MASK: state_next.maskBits = hostByteS2;
							default: state_next.addr = state_reg.addr;
						endcase
						state_next.addr = state_reg.addr - 5'd1;
					end
					state_next.count = state_reg.count - 5'd1;
					if (state_reg.count == 5'd1) begin
						state_next.fsm = scms_pkg::SCMS_IDLE;
					end
				end
			end
			scms_pkg::SCMS_READ: begin
				if (readStrobe) begin
					state_next.outValid = 1'b1;
					if (state_reg.coe) begin
						state_next.outByte = state_reg.count[0]
							? coeMem[state_reg.count[3:1]][7:0]
							: {2'b00, coeMem[state_reg.count[3:1] - 3'd1][13:8]};
					end else if (state_reg.global) begin
						// Only the channel-enable byte is readable in global space
						state_next.outByte = (state_reg.addr == `SCMS_OFF_CHEN) ? state_reg.chen
							: 8'h00;
						state_next.addr = state_reg.addr - 5'd1;
					end else begin
						case (state_reg.addr)
							`SCMS_OFF_LOCAL_TWO: state_next.outByte = state_reg.localTwo;
							`SCMS_OFF_LOCAL_ONE: state_next.outByte = state_reg.localOne;
							`SCMS_OFF_MASK: state_next.outByte = state_reg.maskBits;
							`SCMS_OFF_STATUS: state_next.outByte = statusByte;
							default: state_next.outByte = 8'h00;
						endcase
						state_next.addr = state_reg.addr - 5'd1;
					end
					state_next.count = state_reg.count - 5'd1;
					if (state_reg.count == 5'd1) begin
						state_next.fsm = scms_pkg::SCMS_IDLE;
					end
				end
			end
			default: state_next.fsm = scms_pkg::SCMS_IDLE;
		endcase
	end

	// State register; event level copies reset to the idle level of each source
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_reg <= '{fsm: scms_pkg::SCMS_IDLE, chen: `SCMS_CHEN_RESET,
				localOne: `SCMS_LOCAL_RESET, localTwo: `SCMS_LOCAL_RESET,
				maskBits: `SCMS_MASK_RESET, pending: 5'h00, addr: 5'h00,
				count: 5'h00, coe: 1'b0, global: 1'b0, coeHigh: 8'h00,
				rampSync: 3'b000, rampFlag: 1'b0, startSync: 2'b00,
				lvlSync1: {4'h0, `SCMS_GKPOL_RESET}, lvlSync2: {4'h0, `SCMS_GKPOL_RESET},
				feedSync1: 3'b000, feedSync2: 3'b000,
				outByte: 8'h00, outValid: 1'b0, irqN: 1'b1};
		end else begin
			state_reg <= state_next;
		end
	end

	assign hostByteOut = state_reg.outByte;
	assign hostByteOutValid = state_reg.outValid;
	assign intReqN = state_reg.irqN;
	assign channelEnable = state_reg.chen;
endmodule : scms_top

// >>> scms_chk.sv
// Port-level assertions for the channel programming block
`timescale 1ns/1ps
module scms_chk (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic hostByteValid,
	input wire logic hostReadReq,
	input wire logic levelDone,
	input wire logic toneFound,
	input wire logic [7:0] hostByteOut,
	input wire logic hostByteOutValid,
	input wire logic intReqN,
	input wire logic [7:0] channelEnable
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Idle outputs one edge into reset
	property p_rst;
		disable iff (1'b0) !resetn |=> intReqN && !hostByteOutValid && channelEnable == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("reset output values wrong");
	// Answers are single pulses, three sampled edges after a strobe is first seen
	property p_pulse;
		hostByteOutValid |=> !hostByteOutValid;
	endproperty
	a_pulse: assert property (p_pulse) else $error("answer pulse too long");
	property p_outv;
		hostByteOutValid |-> $past(hostByteValid, 3) || $past(hostReadReq, 3);
	endproperty
	a_outv: assert property (p_outv) else $error("answer without request");
	// Answer byte stands between pulses
	property p_stand;
		!hostByteOutValid |-> $stable(hostByteOut);
	endproperty
	a_stand: assert property (p_stand) else $error("answer byte moved");
	// Unmaskable sources pull the request low quickly
	property p_lvl;
		$rose(levelDone) |-> ##[1:8] !intReqN;
	endproperty
	a_lvl: assert property (p_lvl) else $error("level done gave no interrupt");
	property p_tone;
		$rose(toneFound) |-> ##[1:8] !intReqN;
	endproperty
	a_tone: assert property (p_tone) else $error("tone gave no interrupt");
	// Release only follows a data request
	property p_clr;
		$rose(intReqN) |-> hostReadReq || $past(hostReadReq, 2);
	endproperty
	a_clr: assert property (p_clr) else $error("interrupt released without read");
	property p_chen;
		$changed(channelEnable) |-> hostByteValid || $past(hostByteValid, 2);
	endproperty
	a_chen: assert property (p_chen) else $error("channel enable moved alone");
endmodule : scms_chk
bind scms_top scms_chk scms_chk_i (.sys_clk(sys_clk), .resetn(resetn),
	.hostByteValid(hostByteValid), .hostReadReq(hostReadReq), .levelDone(levelDone),
	.toneFound(toneFound), .hostByteOut(hostByteOut), .hostByteOutValid(hostByteOutValid),
	.intReqN(intReqN), .channelEnable(channelEnable));

// >>> scms_host.sv
// Host processor model strobing bytes into the programming block
`timescale 1ns/1ps
module scms_host (
	input wire logic sys_clk,
	output logic [7:0] hostByteIn,
	output logic hostByteValid,
	output logic hostReadReq
);
	initial begin
		hostByteIn = 8'h00;
		hostByteValid = 1'b0;
		hostReadReq = 1'b0;
	end
	// Byte inverted on release so stale data is never trusted
	task sendByte(input logic [7:0] b);
		@(negedge sys_clk);
		hostByteIn = b;
		hostByteValid = 1'b1;
		repeat (5) @(negedge sys_clk);
		hostByteValid = 1'b0;
		hostByteIn = ~b;
		repeat (3) @(negedge sys_clk);
	endtask : sendByte
	// One request per answer byte, spaced past the minimum
	task readReq();
		@(negedge sys_clk);
		hostReadReq = 1'b1;
		repeat (5) @(negedge sys_clk);
		hostReadReq = 1'b0;
		repeat (3) @(negedge sys_clk);
	endtask : readReq
endmodule : scms_host

// >>> scms_top_bench.sv
// Self-checking bench for the channel programming block
`timescale 1ns/1ps
`include "scms_regs.svh"
module scms_top_bench;
	logic sys_clk, resetn, hostByteValid, hostReadReq, hostByteOutValid, intReqN;
	logic [7:0] hostByteIn, channelSelf, hostByteOut, channelEnable, st;
	logic feedCurrent, feedVoltage, feedResistive, levelDone, toneFound;
	logic overTemp, rampDone, rampStart, gkPositive;
	logic [7:0] expQ[$];
	logic [7:0] coef[16];
	int err_count = 0;
	int cmp_count = 0;
	int i;
	scms_top scms_top_i (.sys_clk(sys_clk), .resetn(resetn), .hostByteIn(hostByteIn),
		.hostByteValid(hostByteValid), .hostReadReq(hostReadReq), .channelSelf(channelSelf),
		.feedCurrent(feedCurrent), .feedVoltage(feedVoltage), .feedResistive(feedResistive),
		.levelDone(levelDone), .toneFound(toneFound), .overTemp(overTemp),
		.rampDone(rampDone), .rampStart(rampStart), .gkPositive(gkPositive),
		.hostByteOut(hostByteOut), .hostByteOutValid(hostByteOutValid), .intReqN(intReqN),
		.channelEnable(channelEnable));
	scms_host scms_host_i (.sys_clk(sys_clk), .hostByteIn(hostByteIn),
		.hostByteValid(hostByteValid), .hostReadReq(hostReadReq));
	task check(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask : check
	task test_done();
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done
	// Read command then n data requests; notes pushed by caller
	task rd(input logic [7:0] cmd, input int n);
		scms_host_i.sendByte(cmd);
		repeat (n) scms_host_i.readReq();
	endtask : rd
	// Status read runs from the status offset down to register one: 21 bytes
	task rdStatus(input logic [7:0] stv, input logic [7:0] mask);
		expQ.push_back(`SCMS_ID_BYTE);
		expQ.push_back(stv);
		repeat (2) expQ.push_back(8'h00);
		expQ.push_back(mask);
		repeat (17) expQ.push_back(8'h00);
		rd({3'b000, `SCMS_OFF_STATUS}, 21);
	endtask : rdStatus
	task waitInt(input logic exp);
		repeat (10) @(negedge sys_clk);
		check("intReqN", {7'h00, exp}, {7'h00, intReqN});
	endtask : waitInt
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Each answer pulse takes the oldest note; a pulse with none noted is a fault
	always @(negedge sys_clk) begin
		if (hostByteOutValid === 1'b1) begin
			if (expQ.size() == 0) begin
				$display("Error answer expected none seen %h", hostByteOut);
				err_count++;
			end else begin
				check("answer", expQ.pop_front(), hostByteOut);
			end
		end
	end
	initial begin
		resetn = 1'b0;
		channelSelf = 8'h02;
		{feedCurrent, feedVoltage, feedResistive, levelDone, toneFound} = 5'b00000;
		{overTemp, rampDone, rampStart, gkPositive} = 4'b0001;
		i = $urandom(95);
		repeat (4) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (4) @(negedge sys_clk);
		waitInt(1'b1);
		check("channelEnable", 8'h00, channelEnable);
		scms_host_i.sendByte(`SCMS_CMD_CHEN);
		scms_host_i.sendByte(8'h12);
		check("channelEnable", 8'h12, channelEnable);
		rdStatus(8'h01, `SCMS_MASK_RESET);
		// Unmaskable event, then status read clears it
		{feedCurrent, feedVoltage, feedResistive} = 3'($urandom);
		levelDone = 1'b1;
		waitInt(1'b0);
		st = {feedCurrent, feedVoltage, feedResistive, 5'b10001};
		rdStatus(st, `SCMS_MASK_RESET);
		waitInt(1'b1);
		// Masked sources stay quiet at reset mask; tone does not
		overTemp = 1'b1;
		gkPositive = 1'b0;
		waitInt(1'b1);
		toneFound = 1'b1;
		waitInt(1'b0);
		// Ramp done shows; a new start clears it while the done level still stands
		rampDone = 1'b1;
		repeat (6) @(negedge sys_clk);
		rdStatus({st[7:5], 5'b11110}, `SCMS_MASK_RESET);
		waitInt(1'b1);
		rampStart = 1'b1;
		@(negedge sys_clk);
		rampStart = 1'b0;
		repeat (6) @(negedge sys_clk);
		rdStatus({st[7:5], 5'b11100}, `SCMS_MASK_RESET);
		// Unmask: the write runs 18 bytes from the mask offset down to register one
		scms_host_i.sendByte({1'b1, 2'b00, `SCMS_OFF_MASK});
		repeat (18) scms_host_i.sendByte(8'h00);
		overTemp = 1'b0;
		waitInt(1'b1);
		overTemp = 1'b1;
		waitInt(1'b0);
		rdStatus({st[7:5], 5'b11100}, 8'h00);
		waitInt(1'b1);
		gkPositive = 1'b1;
		waitInt(1'b0);
		rdStatus({st[7:5], 5'b11101}, 8'h00);
		waitInt(1'b1);
		// Two-register write then read back, descending
		coef[0] = 8'($urandom);
		coef[1] = 8'($urandom);
		scms_host_i.sendByte(8'h81);
		scms_host_i.sendByte(coef[0]);
		scms_host_i.sendByte(coef[1]);
		expQ.push_back(`SCMS_ID_BYTE);
		expQ.push_back(coef[0]);
		expQ.push_back(coef[1]);
		rd(8'h01, 2);
		// Coefficient block: high bytes lose their top two bits
		scms_host_i.sendByte(`SCMS_CMD_COE_WR);
		expQ.push_back(`SCMS_ID_BYTE);
		for (i = 0; i < 16; i++) begin
			coef[i] = 8'($urandom);
			scms_host_i.sendByte(coef[i]);
			expQ.push_back(i[0] ? coef[i] : coef[i] & 8'h3F);
		end
		rd(`SCMS_CMD_COE_RD, 16);
		// Deselected channel must not answer
		scms_host_i.sendByte(`SCMS_CMD_CHEN);
		scms_host_i.sendByte(8'h01);
		check("channelEnable", 8'h01, channelEnable);
		rd(8'h01, 2);
		// Global space answers with no channel selected
		expQ.push_back(`SCMS_ID_BYTE);
		expQ.push_back(8'h01);
		repeat (3) expQ.push_back(8'h00);
		rd({3'b001, `SCMS_OFF_CHEN}, 4);
		for (i = 0; i < 20 && expQ.size() > 0; i++) @(negedge sys_clk);
		check("notes left", 8'h00, 8'(expQ.size()));
		test_done();
	end
endmodule : scms_top_bench
